// file: hw/power_reset_code_protect.sv
// clock division, idle and power-down control, reset filter and code protection
module power_reset_code_protect (
  // clock and power-on reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // external reset pin and interrupt requests
  input  wire logic                          rstPin,
  input  wire logic                          irqPending,
  // core register writes
  input  wire logic                          pconWrEn,
  input  wire logic [3:0]                    portWrEn,
  input  wire logic                          spWrEn,
  input  wire logic                          sbufWrEn,
  input  wire logic [7:0]                    sfrWrData,
  // core table read check
  input  wire logic                          movcReq,
  input  wire logic                          movcFromInternal,
  input  wire logic                          movcTargetInternal,
  // port 0 data from the core
  input  wire logic                          p0WrEn,
  input  wire logic [7:0]                    p0Data,
  // programmer side
  input  wire power_reset_pkg::prog_req_type progReq,
  input  wire logic [7:0]                    nvSecurity,
  input  wire logic [7:0]                    codeRdData,
  // clocks and resets to the rest of the chip
  output logic                               oscRun,
  output logic                               oscGainHalf,
  output logic                               cpuClkEn,
  output logic                               periphClkEn,
  output logic                               coreRst,
  // register views
  output logic [7:0]                         pconRd,
  output logic [3:0][7:0]                    portLatch,
  output logic [7:0]                         stackPtr,
  output logic [7:0]                         sbufRd,
  // table read answer
  output logic                               movcInternalOk,
  // port 0 output
  output logic [7:0]                         p0Out,
  // programmer answers
  output logic                               codeAccessEn,
  output logic                               progRefused,
  output logic [7:0]                         progRdData,
  output power_reset_pkg::security_type      security
);

  // ----------------------------------------------------------------
  // oscillator phase counter and clock enables
  // ----------------------------------------------------------------
  power_reset_pkg::power_state_type pwrState_r, pwrState_nxt;
  logic [3:0] phase_r, phase_nxt;
  logic       stateTick;
  logic       sampleTick;

  always_comb begin
    phase_nxt = phase_r;
    if (oscRun) begin
      phase_nxt = (phase_r == power_reset_pkg::PHASE_LAST) ? 4'h0 : phase_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // each oscillator tick is one phase; two phases make one internal state
  assign oscRun      = (pwrState_r != power_reset_pkg::PDOWN);
  assign stateTick   = oscRun && phase_r[0];
  assign sampleTick  = oscRun && (phase_r == power_reset_pkg::PHASE_S5P2);
  assign periphClkEn = stateTick;
  assign cpuClkEn    = stateTick && (pwrState_r == power_reset_pkg::RUN)
                       && !coreRst;

  // ----------------------------------------------------------------
  // reset pin filter
  // ----------------------------------------------------------------
  // a lone high sample is a glitch; reset needs consecutive samples
  logic [1:0] rstCnt_r, rstCnt_nxt;
  logic       rstAct_r, rstAct_nxt;

  always_comb begin
    rstCnt_nxt = rstCnt_r;
    rstAct_nxt = rstAct_r;
    if (sampleTick) begin
      if (!rstPin) begin
        rstCnt_nxt = 2'h0;
        rstAct_nxt = 1'b0;
      end else if (rstCnt_r < power_reset_pkg::RST_MIN_SAMPLES) begin
        rstCnt_nxt = rstCnt_r + 2'h1;
        rstAct_nxt = (rstCnt_r + 2'h1) >= power_reset_pkg::RST_MIN_SAMPLES;
      end else begin
        rstAct_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rstCnt_r <= 2'h0;
      rstAct_r <= 1'b0;
    end else begin
      rstCnt_r <= rstCnt_nxt;
      rstAct_r <= rstAct_nxt;
    end
  end

  assign coreRst = rstAct_r;

  // ----------------------------------------------------------------
  // power control register and power state
  // ----------------------------------------------------------------
  logic [7:0] power_control_reg_r, power_control_reg_nxt;

  always_comb begin
    pwrState_nxt = pwrState_r;
    power_control_reg_nxt     = power_control_reg_r;
    if (rstAct_r) begin
      power_control_reg_nxt     = power_control_reg_r & power_reset_pkg::POWER_CONTROL_REG_KEEP_MASK;
      pwrState_nxt = power_reset_pkg::RUN;
    end else begin
      if (pconWrEn && (pwrState_r == power_reset_pkg::RUN)) begin
        // the flag may only be cleared by software, never set by it
        power_control_reg_nxt = sfrWrData;
        power_control_reg_nxt[power_reset_pkg::POWER_CONTROL_REG_POF_BIT] = power_control_reg_r[power_reset_pkg::POWER_CONTROL_REG_POF_BIT]
          & sfrWrData[power_reset_pkg::POWER_CONTROL_REG_POF_BIT];
      end
      unique case (pwrState_r)
        power_reset_pkg::RUN: begin
          if (power_control_reg_nxt[power_reset_pkg::POWER_CONTROL_REG_PDOWN_BIT]) begin
            pwrState_nxt = power_reset_pkg::PDOWN;
          end else if (power_control_reg_nxt[power_reset_pkg::POWER_CONTROL_REG_IDLE_BIT]) begin
            pwrState_nxt = power_reset_pkg::IDLE;
          end
        end
        power_reset_pkg::IDLE: begin
          if (irqPending) begin
            pwrState_nxt = power_reset_pkg::RUN;
            power_control_reg_nxt[power_reset_pkg::POWER_CONTROL_REG_IDLE_BIT] = 1'b0;
          end
        end
        power_reset_pkg::PDOWN: begin
          // interrupts are ignored; only the reset pin restarts the oscillator
          if (rstPin) begin
            pwrState_nxt = power_reset_pkg::WAKE;
          end
        end
        power_reset_pkg::WAKE: begin
          // oscillator runs so the filter can qualify the pin; a glitch sleeps again
          if (sampleTick && !rstPin) begin
            pwrState_nxt = power_reset_pkg::PDOWN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      power_control_reg_r     <= power_reset_pkg::POWER_CONTROL_REG_POR_VAL;
      pwrState_r <= power_reset_pkg::RUN;
    end else begin
      power_control_reg_r     <= power_control_reg_nxt;
      pwrState_r <= pwrState_nxt;
    end
  end

  assign pconRd = power_control_reg_r;

  // ----------------------------------------------------------------
  // port latches, stack pointer and serial buffer
  // ----------------------------------------------------------------
  logic [3:0][7:0] port_r, port_nxt;
  logic [7:0]      sp_r, sp_nxt;
  logic [7:0]      serial_buffer_reg_r, serial_buffer_reg_nxt;

  generate
    for (genvar i = 0; i < power_reset_pkg::NUM_PORTS; i++) begin : g_port
      always_comb begin
        port_nxt[i] = port_r[i];
        if (rstAct_r) begin
          port_nxt[i] = power_reset_pkg::PORT_RST_VAL;
        end else if (portWrEn[i]) begin
          port_nxt[i] = sfrWrData;
        end
      end
    end
  endgenerate

  always_comb begin
    sp_nxt   = sp_r;
    serial_buffer_reg_nxt = serial_buffer_reg_r;
    if (rstAct_r) begin
      sp_nxt = power_reset_pkg::SP_RST_VAL;
    end else if (spWrEn) begin
      sp_nxt = sfrWrData;
    end
    // the serial buffer keeps its contents through a pin reset
    if (!rstAct_r && sbufWrEn) begin
      serial_buffer_reg_nxt = sfrWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_r <= {power_reset_pkg::NUM_PORTS{power_reset_pkg::PORT_RST_VAL}};
      sp_r   <= power_reset_pkg::SP_RST_VAL;
      serial_buffer_reg_r <= power_reset_pkg::SFR_RST_VAL;
    end else begin
      port_r <= port_nxt;
      sp_r   <= sp_nxt;
      serial_buffer_reg_r <= serial_buffer_reg_nxt;
    end
  end

  assign portLatch = port_r;
  assign stackPtr  = sp_r;
  assign sbufRd    = serial_buffer_reg_r;

  // ----------------------------------------------------------------
  // protection register and programmer access
  // ----------------------------------------------------------------
  power_reset_pkg::security_type sec_r, sec_nxt;
  logic [7:0] progRd_r, progRd_nxt;
  logic       refused_r, refused_nxt;
  logic       secHit;
  logic       progAccess;

  assign secHit     = (progReq.addr == power_reset_pkg::SEC_ADDR);
  assign progAccess = progReq.mode && (progReq.rdEn || progReq.wrEn);

  always_comb begin
    sec_nxt     = sec_r;
    progRd_nxt  = progRd_r;
    refused_nxt = 1'b0;
    if (progReq.mode && progReq.eraseAll) begin
      sec_nxt = power_reset_pkg::security_type'(power_reset_pkg::SEC_ERASED_VAL);
    end else if (progAccess && !sec_r.unlocked) begin
      refused_nxt = 1'b1;
      progRd_nxt  = power_reset_pkg::SFR_RST_VAL;
    end else if (progAccess) begin
      if (progReq.wrEn && secHit) begin
        // programming can only pull bits from one to zero
        sec_nxt = power_reset_pkg::security_type'(sec_r & progReq.wrData);
      end
      if (progReq.rdEn) begin
        progRd_nxt = secHit ? sec_r : codeRdData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      // the register is non-volatile: its stored image is reloaded at power-on
      sec_r     <= power_reset_pkg::security_type'(nvSecurity);
      progRd_r  <= power_reset_pkg::SFR_RST_VAL;
      refused_r <= 1'b0;
    end else begin
      sec_r     <= sec_nxt;
      progRd_r  <= progRd_nxt;
      refused_r <= refused_nxt;
    end
  end

  assign security     = sec_r;
  assign progRdData   = progRd_r;
  assign progRefused  = refused_r;
  assign codeAccessEn = progAccess && sec_r.unlocked && !secHit;
  assign oscGainHalf  = !sec_r.gainFull;

  // ----------------------------------------------------------------
  // table read restriction
  // ----------------------------------------------------------------
  // only a request aimed at internal code from external space is ever blocked
  assign movcInternalOk = movcReq && movcTargetInternal
                          && (movcFromInternal
                              || sec_r.movcFree);

  // ----------------------------------------------------------------
  // port 0 output with optional encryption
  // ----------------------------------------------------------------
  logic [7:0] p0_r, p0_nxt;

  function automatic logic [7:0] encode(input logic [7:0] d);
    logic [7:0] x;
    x      = d ^ power_reset_pkg::ENC_KEY;
    encode = {x[6:0], x[7]};
  endfunction : encode

  always_comb begin
    p0_nxt = p0_r;
    if (rstAct_r) begin
      p0_nxt = power_reset_pkg::PORT_RST_VAL;
    end else if (p0WrEn) begin
      p0_nxt = sec_r.encOff ? p0Data : encode(p0Data);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      p0_r <= power_reset_pkg::PORT_RST_VAL;
    end else begin
      p0_r <= p0_nxt;
    end
  end

  assign p0Out = p0_r;

endmodule : power_reset_code_protect

// file: pkg/power_reset_pkg.sv
// constants and carrier types for the clock, power, reset and protection block
package power_reset_pkg;

  // ----------------------------------------------------------------
  // machine cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned    PHASES_PER_CYCLE = 12;
  localparam logic [3:0]     PHASE_LAST       = 4'hb;
  localparam logic [3:0]     PHASE_S5P2       = 4'h9;
  localparam logic [1:0]     RST_MIN_SAMPLES  = 2'h2;

  // ----------------------------------------------------------------
  // power control register layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned    POWER_CONTROL_REG_IDLE_BIT    = 0;
  localparam int unsigned    POWER_CONTROL_REG_PDOWN_BIT   = 1;
  localparam int unsigned    POWER_CONTROL_REG_POF_BIT     = 4;
  localparam logic [7:0]     POWER_CONTROL_REG_KEEP_MASK   = 8'h10;
  localparam logic [7:0]     POWER_CONTROL_REG_POR_VAL     = 8'h10;

  // ----------------------------------------------------------------
  // core register reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]     PORT_RST_VAL     = 8'hff;
  localparam logic [7:0]     SP_RST_VAL       = 8'h07;
  localparam logic [7:0]     SFR_RST_VAL      = 8'h00;
  localparam int unsigned    NUM_PORTS        = 4;

  // ----------------------------------------------------------------
  // protection register
  // ----------------------------------------------------------------
  localparam logic [15:0]    SEC_ADDR         = 16'hffff;
  localparam logic [7:0]     SEC_ERASED_VAL   = 8'hff;
  // arbitrary scrambling key
  localparam logic [7:0]     ENC_KEY          = 8'h5a;

  typedef struct packed {
    logic       gainFull;   // 0 halves the amplifier gain
    logic [3:0] spare;
    logic       encOff;     // 0 turns port 0 encryption on
    logic       movcFree;   // 0 restricts table reads from external space
    logic       unlocked;   // 0 locks programmer access
  } security_type;

  typedef struct packed {
    logic        mode;
    logic [15:0] addr;
    logic        rdEn;
    logic        wrEn;
    logic [7:0]  wrData;
    logic        eraseAll;
  } prog_req_type;

  typedef enum logic [1:0] {RUN, IDLE, PDOWN, WAKE} power_state_type;

endpackage : power_reset_pkg

// file: verif/power_reset_chk.sv
// concurrent checks on the ports of the clock, power, reset and protection block
module power_reset_chk (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          srst,
  // inputs watched
  input wire logic                          rstPin,
  input wire logic                          irqPending,
  input wire logic                          movcReq,
  input wire logic                          movcFromInternal,
  input wire logic                          movcTargetInternal,
  input wire logic                          p0WrEn,
  input wire logic [7:0]                    p0Data,
  input wire power_reset_pkg::prog_req_type progReq,
  // outputs watched
  input wire logic                          oscRun,
  input wire logic                          oscGainHalf,
  input wire logic                          cpuClkEn,
  input wire logic                          periphClkEn,
  input wire logic                          coreRst,
  input wire logic [7:0]                    pconRd,
  input wire logic [3:0][7:0]               portLatch,
  input wire logic [7:0]                    stackPtr,
  input wire logic                          movcInternalOk,
  input wire logic [7:0]                    p0Out,
  input wire logic                          progRefused,
  input wire power_reset_pkg::security_type security
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // --------------------------------------------------------------
  // helper logic
  // --------------------------------------------------------------
  // a reset may only follow a high run long enough to span two samples
  logic [3:0] hiRun;
  logic [2:0] sinceLong;
  logic [7:0] mix;
  logic [7:0] p0Exp;
  assign mix   = p0Data ^ power_reset_pkg::ENC_KEY;
  assign p0Exp = security.encOff ? p0Data : {mix[6:0], mix[7]};
  always_ff @(posedge clk) begin
    hiRun     <= (srst || !rstPin) ? 4'h0 : hiRun + {3'h0, hiRun != 4'hf};
    sinceLong <= srst ? 3'h7 : (hiRun >= 4'hc) ? 3'h0 : sinceLong + {2'h0, sinceLong != 3'h7};
  end
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_cpu_half: assert property (cpuClkEn |=> !cpuClkEn)
    else $error("processor clock enable not halved");
  a_periph_half: assert property (periphClkEn |=> !periphClkEn)
    else $error("peripheral clock enable not halved");
  a_idle_stops_cpu: assert property (pconRd[0] |-> !cpuClkEn)
    else $error("processor clocked in idle");
  a_idle_periph_runs: assert property ($rose(pconRd[0]) && !pconRd[1] |-> ##[0:2] periphClkEn)
    else $error("peripherals not clocked in idle");
  a_idle_wake: assert property (pconRd[0] && !pconRd[1] && irqPending && !coreRst
    |=> !pconRd[0] ##[0:2] cpuClkEn) else $error("interrupt did not end idle");
  a_pdown_stops: assert property ($rose(pconRd[1]) |-> !oscRun && !cpuClkEn && !periphClkEn)
    else $error("clocks still running in power-down");
  a_pdown_hold: assert property (!oscRun && !rstPin |=> !oscRun)
    else $error("power-down left without reset");
  a_reset_filter: assert property ($rose(coreRst) |-> sinceLong <= 3'h3 || hiRun >= 4'hc)
    else $error("reset taken from a short pulse");
  a_core_reset_vals: assert property (coreRst |=> stackPtr == power_reset_pkg::SP_RST_VAL
    && portLatch == {4{power_reset_pkg::PORT_RST_VAL}} && (pconRd & 8'hef) == 8'h00)
    else $error("wrong register values under reset");
  a_pof_sticky: assert property (!pconRd[4] |=> !pconRd[4])
    else $error("power-off flag set outside power-on");
  a_prot_one_way: assert property (!(progReq.mode && progReq.eraseAll)
    |=> (security & ~$past(security)) == 8'h00) else $error("protection bit returned to one");
  a_erase_all: assert property (progReq.mode && progReq.eraseAll |=> security == 8'hff)
    else $error("erase-all did not restore protection bits");
  a_lock_refuse: assert property (!security.unlocked && progReq.mode
    && (progReq.rdEn || progReq.wrEn) |=> progRefused) else $error("locked access not refused");
  a_table_read: assert property (movcReq
    |-> movcInternalOk == (movcTargetInternal && (movcFromInternal || security.movcFree)))
    else $error("table read gate wrong");
  a_port0_encrypt: assert property (p0WrEn && !coreRst |=> p0Out == $past(p0Exp))
    else $error("port 0 output wrong");
  a_gain_half: assert property (oscGainHalf != security.gainFull)
    else $error("amplifier gain select wrong");
  c_idle_wake: cover property ($fell(pconRd[0]));
  c_pin_reset: cover property ($rose(coreRst));
  c_refused: cover property (progRefused);
endmodule : power_reset_chk

// file: verif/reset_prog_model.sv
// reset source and device programmer on the far side of the block
module reset_prog_model (
  // clock
  input  wire logic                     clk,
  // driven lines
  output logic                          rstPin,
  output power_reset_pkg::prog_req_type progReq
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rstPin  = 1'b0;
    progReq = '0;
  end
  // n clocks high; short pulses stand in for glitches on the pin
  task automatic pulse(input int n);
    @(posedge clk);
    #1 rstPin = 1'b1;
    repeat (n) @(posedge clk);
    #1 rstPin = 1'b0; // pin has a pull-down, so a release reads low
  endtask : pulse
  // rwe = read, write, erase-all; on release the address and data carry the inverse and the strobes go low, so stale values never match
  task automatic op(input logic [15:0] a, input logic [2:0] rwe, input logic [7:0] d);
    @(posedge clk);
    #1 progReq = '{1'b1, a, rwe[2], rwe[1], d, rwe[0]};
    @(posedge clk);
    #1 progReq = '{1'b0, ~a, 1'b0, 1'b0, ~d, 1'b0};
  endtask : op
endmodule : reset_prog_model

// file: verif/power_reset_code_protect_bench.sv
// self-checking bench for the clock, power, reset and protection block
module power_reset_code_protect_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, rstPin, irqPending, pconWrEn, spWrEn, sbufWrEn, movcReq, movcFromInternal;
  logic movcTargetInternal, p0WrEn, oscRun, oscGainHalf, cpuClkEn, periphClkEn, coreRst;
  logic movcInternalOk, codeAccessEn, progRefused;
  logic [7:0] sfrWrData, p0Data, nvSecurity, codeRdData, pconRd, stackPtr, sbufRd, p0Out, progRdData;
  logic [3:0] portWrEn;
  logic [3:0][7:0] portLatch;
  power_reset_pkg::prog_req_type progReq;
  power_reset_pkg::security_type security;
  int miscompares, comparisons, cycles, a, b;
  power_reset_code_protect dut (.clk, .srst, .rstPin, .irqPending, .pconWrEn, .portWrEn, .spWrEn,
    .sbufWrEn, .sfrWrData, .movcReq, .movcFromInternal, .movcTargetInternal, .p0WrEn, .p0Data,
    .progReq, .nvSecurity, .codeRdData, .oscRun, .oscGainHalf, .cpuClkEn, .periphClkEn, .coreRst,
    .pconRd, .portLatch, .stackPtr, .sbufRd, .movcInternalOk, .p0Out, .codeAccessEn, .progRefused,
    .progRdData, .security);
  reset_prog_model model (.clk, .rstPin, .progReq);
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // sel: 0 power control, 1 port latch 1, 2 stack pointer, 3 serial buffer, 4 port 0
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    #1 sfrWrData = d;
    p0Data = d;
    {p0WrEn, sbufWrEn, spWrEn, portWrEn[1], pconWrEn} = 5'h01 << sel;
    @(posedge clk);
    #1 {p0WrEn, sbufWrEn, spWrEn, portWrEn[1], pconWrEn} = 5'h00;
  endtask : wr
  task automatic count(input int n);
    a = 0;
    b = 0;
    repeat (n) begin
      @(posedge clk);
      #1 a += int'(cpuClkEn);
      b += int'(periphClkEn);
    end
  endtask : count
  task automatic irq();
    @(posedge clk);
    #1 irqPending = 1'b1;
    @(posedge clk);
    #1 irqPending = 1'b0;
  endtask : irq
  task automatic table_read(input logic free);
    movcReq = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1 {movcFromInternal, movcTargetInternal} = i[1:0];
      #1 check(movcInternalOk, i[0] & (i[1] | free));
    end
  endtask : table_read
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic test_power();
    check(pconRd, 8'h10);
    check({stackPtr, sbufRd, p0Out, security}, 32'h0700ffff);
    count(24);
    check(a * 256 + b, 12 * 256 + 12);
    wr(0, 8'h01);
    check(pconRd, 8'h01);
    count(10);
    check(a * 256 + b, 5);
    irq();
    check(pconRd, 8'h00);
    count(10);
    check(a, 5);
    wr(0, 8'h10);
    check(pconRd, 8'h00);
  endtask : test_power
  task automatic test_power_down();
    wr(1, 8'h12);
    wr(2, 8'h30);
    wr(3, 8'h5c);
    wr(0, 8'h0e);
    count(10);
    check({pconRd, oscRun, a[7:0], b[7:0]}, 25'h1c0000);
    irq();
    check(oscRun, 1'b0);
    model.pulse(36);
    check(coreRst, 1'b1);
    repeat (14) @(posedge clk);
    #1 check({pconRd, stackPtr, sbufRd, oscRun, coreRst}, 26'h1d72);
    check(portLatch, 32'hffffffff);
    model.pulse(6);
    a = 0;
    repeat (14) begin
      @(posedge clk);
      #1 a |= int'(coreRst);
    end
    check(a, 0);
  endtask : test_power_down
  task automatic test_protect();
    table_read(1'b1);
    wr(4, 8'ha3);
    check(p0Out, 8'ha3);
    model.op(16'h0010, 3'b100, 8'h00);
    check({progRdData, progRefused}, 9'h078);
    model.op(16'hffff, 3'b010, 8'hf9);
    model.op(16'hffff, 3'b010, 8'hff);
    model.op(16'hffff, 3'b100, 8'h00);
    check({progRdData, security, oscGainHalf}, 17'h1f3f2);
    table_read(1'b0);
    wr(4, 8'ha3);
    check(p0Out, 8'hf3);
    model.op(16'hffff, 3'b010, 8'h79);
    check(oscGainHalf, 1'b1);
    model.op(16'hffff, 3'b010, 8'h78);
    model.op(16'hffff, 3'b100, 8'h00);
    check({progRdData, progRefused}, 9'h001);
    model.op(16'hffff, 3'b010, 8'h00);
    check({security, progRefused}, 9'h0f1);
    model.op(16'h0000, 3'b001, 8'h00);
    check({security, oscGainHalf}, 9'h1fe);
  endtask : test_protect
  // --------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    {srst, irqPending, pconWrEn, portWrEn, spWrEn, sbufWrEn, sfrWrData} = {1'b1, 16'h0};
    {movcReq, movcFromInternal, movcTargetInternal, p0WrEn, p0Data} = 12'h0a5;
    nvSecurity = 8'hff;
    codeRdData = 8'h3c;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    test_power();
    test_power_down();
    test_protect();
    final_report();
  end
endmodule : power_reset_code_protect_bench
bind power_reset_code_protect power_reset_chk chk (.clk, .srst, .rstPin, .irqPending, .movcReq,
  .movcFromInternal, .movcTargetInternal, .p0WrEn, .p0Data, .progReq, .oscRun, .oscGainHalf,
  .cpuClkEn, .periphClkEn,
  .coreRst, .pconRd, .portLatch, .stackPtr, .movcInternalOk, .p0Out, .progRefused, .security);
